// [src/cbf_timing.sv]
/*
 * Breaker failure supervision: pick-up criteria, retrip and failure timers,
 * events, cumulative counters and a twelve-entry operation log.
 * Assumes measurements, block and settings come from same-clock logic; the
 * output monitor and the dedicated signal input are pins.
 */
// Behaviour
// - current-only: phase or residual over threshold starts both timers
// - current-only: trip output ignored; outputs when current persists for each delay
// - current-only: timers cleared once all currents fall below thresholds
// - current-and-output: timers halted after pick-up until trip output is active
// - current-and-output: outputs assert on delay expiry while both conditions hold
// - current-and-output: timers reset when current drops or trip output releases
// - current-or-output: counting starts on current or trip output
// - current-or-output: pick-up held while either persists; outputs after each delay
// - current-or-output: reset only when current low and trip output released
// - retrip unused: only the failure timer runs with the same conditions
// - signal criterion: failure timer starts on input, output after delay
// - time-stamped on/off events for eight sources, user selects stored direction
// - resettable counters for retrip, failure, start and blocked occurrences
// - circular log of last twelve records, captured on on events, ms stamp
// - record holds event, max phase, residual, times to outputs, group
// - block at pick-up gives blocked; block after start releases start
// - retrip enable off: no retrip output, retrip delay unused
// - delays in 5 ms steps, defaults 100 ms and 200 ms
// - criterion setting selects current, signal, output or combinations
`timescale 1ns/10ps
`include "cbf_defs.svh"

module cbf_timing
	import cbf_pkg::*;
#(
	parameter int PROC_CYC = `CBF_PROC_CYC,
	parameter int MS_CYC   = `CBF_MS_CYC
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         ce_i,
	input  wire cbf_meas_t    meas_i,
	input  wire logic [15:0]  phase_current_threshold_i,
	input  wire logic [15:0]  residual_current_threshold_i,
	input  wire cbf_res_sel_t res_sel_i,
	input  wire cbf_mode_t    mode_i,
	input  wire logic         retrip_en_i,
	input  wire logic [18:0]  redundant_coil_delay_i,
	input  wire logic [18:0]  failure_delay_i,
	input  wire logic [2:0]   group_i,
	input  wire logic         block_i,
	input  wire logic         trip_mon_i,
	input  wire logic         signal_i,
	input  wire logic [1:0]   ev_store_i,
	input  wire logic         cnt_clr_i,
	input  wire logic [3:0]   log_idx_i,
	output logic              start_o,
	output logic              blocked_o,
	output logic              retrip_o,
	output logic              breaker_failure_out_o,
	output logic              ev_valid_o,
	output cbf_event_t        ev_o,
	output logic [15:0]       retrip_cnt_o,
	output logic [15:0]       failure_cnt_o,
	output logic [15:0]       start_cnt_o,
	output logic [15:0]       block_cnt_o,
	output cbf_rec_t          log_rd_o
);

	function automatic logic [15:0] max2(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? a : b;
	endfunction : max2

	logic        mon_s1_r, mon_s2_r, sig_s1_r, sig_s2_r;
	logic [19:0] proc_div_r;
	logic [16:0] ms_div_r;
	logic        tick_r;
	logic [31:0] stamp_r;
	logic [15:0] max_ph_r, res_r;
	logic        ph_pu_r, res_pu_r;
	logic        cur, pu, run;
	logic        start_r, blocked_r, retrip_r, bf_r;
	logic [18:0] ret_cnt_r, bf_cnt_r;
	logic [7:0]  lv, lv_prev_r, pend_r, dir_r, gnt;
	logic [2:0]  gnt_idx;
	logic        ret_act;
	cbf_rec_t    log_mem [`CBF_LOG_DEPTH];
	logic [3:0]  wptr_r;

	// pin inputs pass two flops before use
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{mon_s1_r, mon_s2_r, sig_s1_r, sig_s2_r} <= 4'h0;
		end else if (ce_i) begin
			mon_s1_r <= trip_mon_i;
			mon_s2_r <= mon_s1_r;
			sig_s1_r <= signal_i;
			sig_s2_r <= sig_s1_r;
		end
	end

	// processing cycle tick and millisecond stamp
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			proc_div_r <= 20'h0_0000;
			ms_div_r   <= 17'h0_0000;
			tick_r     <= 1'b0;
			stamp_r    <= 32'h0000_0000;
		end else if (ce_i) begin
			tick_r     <= (proc_div_r == 20'(PROC_CYC - 1));
			proc_div_r <= (proc_div_r == 20'(PROC_CYC - 1)) ? 20'h0_0000 : proc_div_r + 20'h0_0001;
			ms_div_r   <= (ms_div_r == 17'(MS_CYC - 1)) ? 17'h0_0000 : ms_div_r + 17'h0_0001;
			if (ms_div_r == 17'(MS_CYC - 1))
				stamp_r <= stamp_r + 32'h0000_0001;
		end
	end

	// current pick-up; residual source chosen by setting
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{max_ph_r, res_r} <= 32'h0000_0000;
			{ph_pu_r, res_pu_r} <= 2'b00;
		end else if (ce_i) begin
			max_ph_r <= max2(max2(meas_i.phase_a, meas_i.phase_b), meas_i.phase_c);
			case (res_sel_i)
				CBF_RES_ONE:  res_r <= meas_i.residual_input_one;
				CBF_RES_TWO:  res_r <= meas_i.residual_input_two;
				CBF_RES_CALC: res_r <= meas_i.residual_calc;
				default:      res_r <= 16'h0000;
			endcase
			ph_pu_r  <= max_ph_r > phase_current_threshold_i;
			res_pu_r <= (res_sel_i != CBF_RES_NONE) && (res_r > residual_current_threshold_i);
		end
	end

	// criterion: pick-up starts, run lets timers count
	always_comb begin
		cur = ph_pu_r | res_pu_r;
		case (mode_i)
			CBF_CUR_ONLY: begin
				pu  = cur;
				run = cur;
			end
			CBF_DO_ONLY: begin
				pu  = mon_s2_r;
				run = mon_s2_r;
			end
			CBF_SIG_ONLY: begin
				pu  = sig_s2_r;
				run = sig_s2_r;
			end
			CBF_CUR_AND_DO: begin
				pu  = cur;
				run = cur & mon_s2_r;
			end
			CBF_CUR_OR_DO: begin
				pu  = cur | mon_s2_r;
				run = cur | mon_s2_r;
			end
			CBF_CUR_OR_SIG: begin
				pu  = cur | sig_s2_r;
				run = cur | sig_s2_r;
			end
			CBF_SIG_OR_DO: begin
				pu  = sig_s2_r | mon_s2_r;
				run = sig_s2_r | mon_s2_r;
			end
			default: begin
				pu  = 1'b0;
				run = 1'b0;
			end
		endcase
	end

	// retrip timer only exists while enabled
	assign ret_act = retrip_en_i & start_r & run;

	// start and blocked; blocking forces a release of start
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_r   <= 1'b0;
			blocked_r <= 1'b0;
		end else if (ce_i) begin
			start_r   <= pu & ~block_i;
			blocked_r <= pu & block_i;
		end
	end

	// two independent timers, stepped on the processing tick
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ret_cnt_r <= 19'h0_0000;
			bf_cnt_r  <= 19'h0_0000;
		end else if (ce_i) begin
			if (!ret_act)
				ret_cnt_r <= 19'h0_0000;
			else if (tick_r && ret_cnt_r < redundant_coil_delay_i)
				ret_cnt_r <= ret_cnt_r + 19'h0_0001;
			if (!(start_r & run))
				bf_cnt_r <= 19'h0_0000;
			else if (tick_r && bf_cnt_r < failure_delay_i)
				bf_cnt_r <= bf_cnt_r + 19'h0_0001;
		end
	end

	// outputs once each condition has lasted its delay (5 ms steps)
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			retrip_r <= 1'b0;
			bf_r     <= 1'b0;
		end else if (ce_i) begin
			retrip_r <= ret_act && ret_cnt_r >= redundant_coil_delay_i;
			bf_r     <= start_r && run && bf_cnt_r >= failure_delay_i;
		end
	end

	assign start_o               = start_r;
	assign blocked_o             = blocked_r;
	assign retrip_o              = retrip_r;
	assign breaker_failure_out_o = bf_r;

	// event sources, lowest index served first
	assign lv = {res_pu_r, ph_pu_r, sig_s2_r, mon_s2_r, blocked_r, bf_r, retrip_r, start_r};
	assign gnt = pend_r & (~pend_r + 8'h01);

	always_comb begin
		gnt_idx = 3'h0;
		for (int i = 0; i < 8; i++) begin
			if (gnt[i])
				gnt_idx = 3'(i);
		end
	end

	// pending changes; a new change wins over the grant that clears it
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lv_prev_r  <= 8'h00;
			pend_r     <= 8'h00;
			dir_r      <= 8'h00;
			ev_valid_o <= 1'b0;
			ev_o       <= '0;
		end else if (ce_i) begin
			lv_prev_r  <= lv;
			pend_r     <= (pend_r & ~gnt) | (lv ^ lv_prev_r);
			dir_r      <= (dir_r & ~(lv ^ lv_prev_r)) | (lv & (lv ^ lv_prev_r));
			ev_valid_o <= (gnt != 8'h00) && ev_store_i[dir_r[gnt_idx] ? 0 : 1];
			ev_o       <= '{source: gnt_idx, on: dir_r[gnt_idx], stamp_ms: stamp_r};
		end
	end

	// cumulative counters; an occurrence in the clear cycle still counts
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{retrip_cnt_o, failure_cnt_o} <= 32'h0000_0000;
			{start_cnt_o, block_cnt_o}    <= 32'h0000_0000;
		end else if (ce_i) begin
			retrip_cnt_o  <= (cnt_clr_i ? 16'h0000 : retrip_cnt_o)
				+ 16'(lv[1] & ~lv_prev_r[1]);
			failure_cnt_o <= (cnt_clr_i ? 16'h0000 : failure_cnt_o)
				+ 16'(lv[2] & ~lv_prev_r[2]);
			start_cnt_o   <= (cnt_clr_i ? 16'h0000 : start_cnt_o)
				+ 16'(lv[0] & ~lv_prev_r[0]);
			block_cnt_o   <= (cnt_clr_i ? 16'h0000 : block_cnt_o)
				+ 16'(lv[3] & ~lv_prev_r[3]);
		end
	end

	// log written on every granted on event, oldest overwritten
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr_r <= 4'h0;
		end else if (ce_i && gnt != 8'h00 && dir_r[gnt_idx]) begin
			wptr_r <= (wptr_r == 4'(`CBF_LOG_DEPTH - 1)) ? 4'h0 : wptr_r + 4'h1;
		end
	end

	// log storage has no reset; reads of unwritten slots are undefined until filled
	always_ff @(posedge clk_i) begin
		if (ce_i && gnt != 8'h00 && dir_r[gnt_idx]) begin
			log_mem[wptr_r] <= '{stamp_ms: stamp_r, source: gnt_idx, max_phase: max_ph_r,
				residual: res_r, to_retrip: redundant_coil_delay_i - ret_cnt_r,
				to_failure: failure_delay_i - bf_cnt_r, group: group_i};
		end
	end

	// registered log read, zero outside the twelve slots
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			log_rd_o <= '0;
		else if (ce_i)
			log_rd_o <= (log_idx_i < 4'(`CBF_LOG_DEPTH)) ? log_mem[log_idx_i] : '0;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	retrip_off_a: assert property ((!retrip_en_i && ce_i) |=> !retrip_o)
		else $error("retrip asserted while disabled");
	cur_clear_a: assert property ((mode_i == CBF_CUR_ONLY && !cur && ce_i)
		|=> bf_cnt_r == 19'h0_0000)
		else $error("failure timer kept running without current");
	halt_mon_a: assert property ((mode_i == CBF_CUR_AND_DO && !mon_s2_r && ce_i)
		|=> (ret_cnt_r == 19'h0_0000 && bf_cnt_r == 19'h0_0000))
		else $error("timers counted without trip output");
	or_count_a: assert property ((mode_i == CBF_CUR_OR_DO && start_r && run && tick_r && ce_i
		&& bf_cnt_r < failure_delay_i) |=> bf_cnt_r == $past(bf_cnt_r) + 19'h0_0001)
		else $error("failure timer did not advance");
	block_start_a: assert property ((block_i && ce_i) |=> !start_o && (blocked_o == $past(pu)))
		else $error("start not released by block");
	bf_delay_a: assert property ($rose(bf_r) |-> $past(bf_cnt_r) >= $past(failure_delay_i))
		else $error("failure output before delay");
	sig_idle_a: assert property ((mode_i == CBF_SIG_ONLY && !sig_s2_r && ce_i) |=> !bf_r)
		else $error("failure output without signal");
	fail_count_a: assert property (($rose(bf_r) && !cnt_clr_i && ce_i)
		|=> failure_cnt_o == $past(failure_cnt_o) + 16'h0001)
		else $error("failure counter missed an occurrence");
	log_ptr_a: assert property (wptr_r < 4'(`CBF_LOG_DEPTH))
		else $error("log pointer out of range");
	// direction comes from the event now shown, selection from the edge that launched it
	ev_store_a: assert property (ev_valid_o
		|-> (ev_o.on ? $past(ev_store_i[0]) : $past(ev_store_i[1])))
		else $error("event stored against selection");

	retrip_seen_c: cover property ($rose(retrip_r));
	fail_seen_c:   cover property ($rose(bf_r) && mode_i == CBF_CUR_AND_DO);
	block_seen_c:  cover property ($rose(blocked_r));
	log_wrap_c:    cover property (wptr_r == 4'(`CBF_LOG_DEPTH - 1) ##1 wptr_r == 4'h0);

endmodule : cbf_timing

// [pkg/cbf_defs.svh]
/*
 * Constants of the breaker failure timing block: timing counts, default delays,
 * log depth and event source codes. Assumes a 125 MHz system clock and a 5 ms processing cycle.
 */
`ifndef CBF_DEFS_SVH
`define CBF_DEFS_SVH

`define CBF_CLK_KHZ      125000
`define CBF_PROC_MS      5
`define CBF_STAMP_MS     1
`define CBF_PROC_CYC     (`CBF_PROC_MS * `CBF_CLK_KHZ)
`define CBF_MS_CYC       (`CBF_STAMP_MS * `CBF_CLK_KHZ)
`define CBF_RETR_DLY_DEF 19'h0_0014
`define CBF_BF_DLY_DEF   19'h0_0028
`define CBF_LOG_DEPTH    12
`define CBF_EV_START     3'h0
`define CBF_EV_RETRIP    3'h1
`define CBF_EV_BF        3'h2
`define CBF_EV_BLOCK     3'h3
`define CBF_EV_DOMON     3'h4
`define CBF_EV_SIGNAL    3'h5
`define CBF_EV_PHASE     3'h6
`define CBF_EV_RES       3'h7

`endif

// [pkg/cbf_pkg.sv]
/*
 * Types of the breaker failure timing block: criterion and residual source
 * selections, measurement bundle, event and log record layouts.
 * Assumes measurements arrive already scaled to the threshold units.
 */
package cbf_pkg;

	typedef enum logic [2:0] {
		CBF_CUR_ONLY   = 3'b000,
		CBF_DO_ONLY    = 3'b001,
		CBF_SIG_ONLY   = 3'b010,
		CBF_CUR_AND_DO = 3'b011,
		CBF_CUR_OR_DO  = 3'b100,
		CBF_CUR_OR_SIG = 3'b101,
		CBF_SIG_OR_DO  = 3'b110
	} cbf_mode_t;

	typedef enum logic [1:0] {
		CBF_RES_NONE = 2'b00,
		CBF_RES_ONE  = 2'b01,
		CBF_RES_TWO  = 2'b10,
		CBF_RES_CALC = 2'b11
	} cbf_res_sel_t;

	typedef struct packed {
		logic [15:0] phase_a;
		logic [15:0] phase_b;
		logic [15:0] phase_c;
		logic [15:0] residual_input_one;
		logic [15:0] residual_input_two;
		logic [15:0] residual_calc;
	} cbf_meas_t;

	typedef struct packed {
		logic [2:0]  source;
		logic        on;
		logic [31:0] stamp_ms;
	} cbf_event_t;

	typedef struct packed {
		logic [31:0] stamp_ms;
		logic [2:0]  source;
		logic [15:0] max_phase;
		logic [15:0] residual;
		logic [18:0] to_retrip;
		logic [18:0] to_failure;
		logic [2:0]  group;
	} cbf_rec_t;

endpackage : cbf_pkg

// [tb/cbf_breaker_model.sv]
/*
 * partner model: primary breaker trip contact and coil operation counters.
 * assumes the bench drives the trip command just after clk_i rising edges.
 */
`timescale 1ns/10ps
module cbf_breaker_model #(
	parameter int CLOSE_CYC = 2
) (
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	input  wire logic  trip_cmd_i,
	input  wire logic  retrip_i,
	input  wire logic  failure_i,
	output logic       trip_mon_o,
	output logic [7:0] retrip_ops_o,
	output logic [7:0] failure_ops_o
);
	logic [CLOSE_CYC-1:0] dly_r;
	logic                 ret_r;
	logic                 bf_r;

	// contact lags the command: a real relay never closes in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dly_r <= '0;
		end else begin
			dly_r <= {dly_r[CLOSE_CYC-2:0], trip_cmd_i};
		end
	end
	assign trip_mon_o = dly_r[CLOSE_CYC-1];

	// coil operations counted on energising edges only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ret_r         <= 1'b0;
			bf_r          <= 1'b0;
			retrip_ops_o  <= 8'h00;
			failure_ops_o <= 8'h00;
		end else begin
			ret_r <= retrip_i;
			bf_r  <= failure_i;
			if (retrip_i && !ret_r) begin
				retrip_ops_o <= retrip_ops_o + 8'h01;
			end
			if (failure_i && !bf_r) begin
				failure_ops_o <= failure_ops_o + 8'h01;
			end
		end
	end
endmodule : cbf_breaker_model

// [tb/cbf_timing_test.sv]
/*
 * self-checking bench of the breaker failure timing block.
 * assumes short processing ticks (4 clocks) and delays in tick units.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module cbf_timing_test;
	import cbf_pkg::*;
	logic         clk_i = 1'b0;
	logic         rst_n_i = 1'b0;
	logic         ce_i = 1'b1;
	cbf_meas_t    meas_i = '0;
	cbf_mode_t    mode_i = CBF_CUR_ONLY;
	logic         retrip_en_i = 1'b1;
	logic         block_i = 1'b0;
	logic         trip_cmd = 1'b0;
	logic         signal_i = 1'b0;
	logic         cnt_clr_i = 1'b0;
	cbf_res_sel_t res_sel_i = CBF_RES_NONE;
	logic [2:0]   group_i = 3'h1;
	logic [1:0]   ev_store_i = 2'h3;
	logic [3:0]   log_idx_i = 4'h0;
	logic         trip_mon;
	logic         start_o, blocked_o, retrip_o, breaker_failure_out_o, ev_valid_o;
	cbf_event_t   ev_o;
	cbf_rec_t     log_rd_o;
	logic [15:0]  retrip_cnt_o, failure_cnt_o, start_cnt_o, block_cnt_o;
	logic [7:0]   ret_ops, bf_ops;
	int           failures = 0;
	int           cmp_count = 0;
	int           start_on = 0;
	int           on_cnt = 0;
	int           off_cnt = 0;
	int           off_snap = 0;
	logic         ok;

	cbf_timing #(.PROC_CYC(4), .MS_CYC(2)) i_cbf_timing (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .meas_i(meas_i),
		.phase_current_threshold_i(16'h0080), .residual_current_threshold_i(16'h0080),
		.res_sel_i(res_sel_i), .mode_i(mode_i), .retrip_en_i(retrip_en_i),
		.redundant_coil_delay_i(19'h0_0002), .failure_delay_i(19'h0_0004),
		.group_i(group_i), .block_i(block_i), .trip_mon_i(trip_mon), .signal_i(signal_i),
		.ev_store_i(ev_store_i), .cnt_clr_i(cnt_clr_i), .log_idx_i(log_idx_i),
		.start_o(start_o), .blocked_o(blocked_o), .retrip_o(retrip_o),
		.breaker_failure_out_o(breaker_failure_out_o), .ev_valid_o(ev_valid_o),
		.ev_o(ev_o), .retrip_cnt_o(retrip_cnt_o), .failure_cnt_o(failure_cnt_o),
		.start_cnt_o(start_cnt_o), .block_cnt_o(block_cnt_o), .log_rd_o(log_rd_o));

	cbf_breaker_model i_cbf_breaker_model (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .trip_cmd_i(trip_cmd), .retrip_i(retrip_o),
		.failure_i(breaker_failure_out_o), .trip_mon_o(trip_mon),
		.retrip_ops_o(ret_ops), .failure_ops_o(bf_ops));

	// 125 MHz
	always #4 clk_i = ~clk_i;

	// events seen on the event port: start ons, every on, every off
	always @(posedge clk_i) begin
		if (ev_valid_o === 1'b1 && ev_o.source === 3'h0 && ev_o.on === 1'b1) begin
			start_on++;
		end
		if (ev_valid_o === 1'b1 && ev_o.on === 1'b1) begin
			on_cnt++;
		end
		if (ev_valid_o === 1'b1 && ev_o.on === 1'b0) begin
			off_cnt++;
		end
	end

	function automatic logic pick(input int w);
		case (w)
			0: pick = start_o;
			1: pick = retrip_o;
			2: pick = breaker_failure_out_o;
			default: pick = blocked_o;
		endcase
	endfunction : pick

	// bounded wait for an output level; caller compares afterwards
	task automatic wt(input int w, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(w) !== v && n < lim) begin
			@(posedge clk_i);
			#1;
			n++;
		end
	endtask : wt

	// ok stays high only if the output never leaves v for n cycles
	task automatic hold(input int w, input logic v, input int n);
		ok = 1'b1;
		repeat (n) begin
			@(posedge clk_i);
			#1;
			if (pick(w) !== v) begin
				ok = 1'b0;
			end
		end
	endtask : hold

	task automatic go(input cbf_mode_t m, input logic [15:0] cur, input logic tc,
		input logic sg);
		@(posedge clk_i);
		mode_i   <= m;
		meas_i   <= {cur, 80'h0};
		trip_cmd <= tc;
		signal_i <= sg;
	endtask : go

	task automatic clr;
		@(posedge clk_i);
		cnt_clr_i <= 1'b1;
		@(posedge clk_i);
		cnt_clr_i <= 1'b0;
	endtask : clr

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// hang guard, far above the expected run length
	initial begin
		#40000;
		failures++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// current only, primary trip contact left open
		go(CBF_CUR_ONLY, 16'h0100, 1'b0, 1'b0);
		wt(0, 1'b1, 10);
		`CHK(start_o, 1'b1)
		wt(1, 1'b1, 40);
		`CHK(retrip_o, 1'b1)
		`CHK(breaker_failure_out_o, 1'b0)
		wt(2, 1'b1, 40);
		`CHK(breaker_failure_out_o, 1'b1)
		go(CBF_CUR_ONLY, 16'h0080, 1'b0, 1'b0);
		wt(2, 1'b0, 8);
		`CHK({retrip_o, breaker_failure_out_o}, 2'b00)
		`CHK({start_cnt_o, retrip_cnt_o, failure_cnt_o}, 48'h0001_0001_0001)
		`CHK(start_on, 1)
		`CHK({ret_ops, bf_ops}, 16'h0101)
		$display("test current_only done");
		// current and output: halted until contact closes
		clr();
		go(CBF_CUR_AND_DO, 16'h0100, 1'b0, 1'b0);
		hold(1, 1'b0, 40);
		`CHK(ok, 1'b1)
		go(CBF_CUR_AND_DO, 16'h0100, 1'b1, 1'b0);
		wt(2, 1'b1, 40);
		`CHK({retrip_o, breaker_failure_out_o}, 2'b11)
		go(CBF_CUR_AND_DO, 16'h0100, 1'b0, 1'b0);
		wt(2, 1'b0, 10);
		`CHK(breaker_failure_out_o, 1'b0)
		`CHK(retrip_cnt_o, 16'h0001)
		$display("test current_and_output done");
		// current or output: contact alone, then current alone
		go(CBF_CUR_OR_DO, 16'h0000, 1'b1, 1'b0);
		wt(2, 1'b1, 40);
		`CHK(breaker_failure_out_o, 1'b1)
		go(CBF_CUR_OR_DO, 16'h0100, 1'b0, 1'b0);
		hold(2, 1'b1, 12);
		`CHK(ok, 1'b1)
		go(CBF_CUR_OR_DO, 16'h0000, 1'b0, 1'b0);
		wt(2, 1'b0, 10);
		`CHK(breaker_failure_out_o, 1'b0)
		$display("test current_or_output done");
		// dedicated input with retrip unused
		@(posedge clk_i);
		retrip_en_i <= 1'b0;
		go(CBF_SIG_ONLY, 16'h0000, 1'b0, 1'b1);
		wt(2, 1'b1, 40);
		`CHK(breaker_failure_out_o, 1'b1)
		`CHK(retrip_o, 1'b0)
		go(CBF_SIG_ONLY, 16'h0000, 1'b0, 1'b0);
		wt(2, 1'b0, 10);
		`CHK(breaker_failure_out_o, 1'b0)
		$display("test signal_only done");
		// residual pick-up, only on events stored, log read, frozen clock enable
		@(posedge clk_i);
		mode_i     <= CBF_CUR_ONLY;
		meas_i     <= {48'h0, 16'h0100, 32'h0};
		res_sel_i  <= CBF_RES_ONE;
		group_i    <= 3'h5;
		ev_store_i <= 2'b01;
		wt(0, 1'b1, 10);
		`CHK(start_o, 1'b1)
		// the start on event is the latest log entry two edges later
		repeat (4) @(posedge clk_i);
		log_idx_i <= 4'((on_cnt - 1) % 12);
		@(posedge clk_i);
		#1;
		`CHK({log_rd_o.source, log_rd_o.residual, log_rd_o.group}, {3'h0, 16'h0100, 3'h5})
		`CHK({log_rd_o.max_phase, log_rd_o.to_retrip}, {16'h0000, 19'h0_0002})
		off_snap = off_cnt;
		@(posedge clk_i);
		ce_i <= 1'b0;
		hold(2, 1'b0, 20);
		`CHK(ok, 1'b1)
		@(posedge clk_i);
		ce_i <= 1'b1;
		wt(2, 1'b1, 40);
		`CHK(breaker_failure_out_o, 1'b1)
		go(CBF_CUR_ONLY, 16'h0000, 1'b0, 1'b0);
		wt(2, 1'b0, 10);
		repeat (6) @(posedge clk_i);
		`CHK(off_cnt, off_snap)
		ev_store_i  <= 2'b11;
		res_sel_i   <= CBF_RES_NONE;
		retrip_en_i <= 1'b1;
		$display("test residual_log done");
		// block present at pick-up, then block after start
		clr();
		block_i <= 1'b1;
		go(CBF_CUR_ONLY, 16'h0100, 1'b0, 1'b0);
		wt(3, 1'b1, 10);
		`CHK({blocked_o, start_o}, 2'b10)
		hold(3, 1'b1, 1);
		`CHK(ok, 1'b1)
		`CHK(block_cnt_o, 16'h0001)
		go(CBF_CUR_ONLY, 16'h0000, 1'b0, 1'b0);
		block_i <= 1'b0;
		// let the current pipeline drain so start is low before re-pick-up
		repeat (4) @(posedge clk_i);
		go(CBF_CUR_ONLY, 16'h0100, 1'b0, 1'b0);
		wt(0, 1'b1, 10);
		@(posedge clk_i);
		block_i <= 1'b1;
		wt(0, 1'b0, 4);
		`CHK(start_o, 1'b0)
		`CHK(blocked_o, 1'b1)
		hold(2, 1'b0, 30);
		`CHK(ok, 1'b1)
		$display("test block done");
		close_out();
	end
endmodule : cbf_timing_test
